// File: exu_top.sv
// Exception priority, state save and restore unit
// Notes on behaviour
// - Reset and machine check preempt everything immediately.
// - Instruction exceptions taken singly in program order.
// - Maskable async held off by higher exceptions.
// - Recoverable only when store queue drained, completion done.
// - Fixed class order reset through thermal.
// - Fixed-point load/store cause order.
// - Floating-point load/store cause order.
// - FP ops and vector ops cause order.
// - Return and state move: FP program; trace on state move only.
// - Other instructions: program group, trace, assist, fetch.
// - Return address bits 0:61, low two zero.
// - Save this or next address per exception.
// - Save status: cause bits plus old state word.
// - Width bit; hypervisor set/clear restrictions.
// - Vector unavailable blocks vector instructions.
// - External enable gates maskable async sources.
// - User level blocks privileged ops in fixed-point load/store, other and branch classes only; FP unavailable blocks FP.
// - Machine check disabled means checkstop.
// - Step and branch trace after success.
// - Translation enable bits instruction and data.
// - Recoverable flag saved for handler inspection.
// - FE bits: off when both zero, else precise.
// - Resume at vector plus interrupt offset.
// - Entry clears state word except hypervisor and machine check enable (cleared on machine check entry), sets width bit.
// - Return restores state word, clears energy bit.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module exu_top
    import exu_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_clk_en,
    input  wire exu_pkg::exu_cmp_t    i_cmp,
    input  wire exu_pkg::exu_async_t  i_async,
    input  wire logic                 i_store_q_empty,
    input  wire logic                 i_store_q_cancel,
    input  wire logic [ADDR_W-1:0]    i_addr,
    input  wire logic [63:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic [63:0]               o_rdata,
    output exu_pkg::exu_out_t         o_exc,
    output logic [63:0]               o_msw,
    output logic                      o_cmp_ok
);
    import exu_pkg::*;

    initial begin
        if (ADDR_W < 3) $error("ADDR_W too small for register map");
    end

    typedef struct packed {
        logic [63:0]  sra;
        logic [63:0]  sms;
        logic [63:0]  msw;
        logic [63:0]  hior;
        logic [63:0]  rdata;
        exu_out_t     exc;
        logic         cmp_ok;
        logic         checkstop;
    } exu_state_t;

    exu_state_t st_r;
    exu_state_t st_nxt;
    logic       rst_s1_r;
    logic       rst_s2_r;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    logic [NSRC-1:0] req;
    logic [NSRC-1:0] win;
    logic            therm_win;
    logic            trace_ok;
    logic            async_en;
    logic [63:0]     vec;
    logic [63:0]     save_ea;
    logic [63:0]     m;
    exu_exc_t        sel;

    always_comb begin
        m        = st_r.msw;
        async_en = m[bix(MSW_EXT_EN)];
        // Trace qualifies for a valid instruction other than isync, syscall or return, under step or branch trace
        trace_ok = i_cmp.valid && !i_cmp.isync && !i_cmp.syscall
                   && i_cmp.iclass != IC_RFI
                   && (m[bix(MSW_STEP)]
                       || (m[bix(MSW_BRTRACE)] && i_cmp.iclass == IC_BRANCH));
        req = '0;
        req[19] = i_async.srst;
        req[18] = i_async.mchk;
        if (i_cmp.valid) begin
            unique case (i_cmp.iclass)
                IC_FXLS: begin
                    req[17] = i_cmp.ill;
                    req[16] = i_cmp.priv_op && m[bix(MSW_USER)];
                    req[10] = i_cmp.dseg;
                    req[9]  = i_cmp.dsto;
                    req[8]  = i_cmp.align;
                    req[7]  = trace_ok;
                end
                IC_FPLS: begin
                    req[15] = !m[bix(MSW_FP)];
                    req[10] = i_cmp.dseg;
                    req[9]  = i_cmp.dsto;
                    req[8]  = i_cmp.align;
                    req[7]  = trace_ok;
                end
                IC_FPOP: begin
                    req[15] = !m[bix(MSW_FP)];
                    req[14] = i_cmp.fp_exc
                              && (m[bix(MSW_FE0)] || m[bix(MSW_FE1)]);
                    req[7]  = trace_ok;
                end
                IC_VEC: begin
                    req[13] = !m[bix(MSW_VEC)];
                    req[7]  = trace_ok;
                end
                IC_RFI, IC_MTSW: begin
                    req[14] = i_cmp.fp_exc
                              && (m[bix(MSW_FE0)] || m[bix(MSW_FE1)]);
                    req[7]  = trace_ok && i_cmp.iclass == IC_MTSW;
                end
                IC_OTHER, IC_BRANCH: begin
                    req[12] = i_cmp.trap;
                    req[11] = i_cmp.syscall;
                    req[16] = i_cmp.priv_op && m[bix(MSW_USER)];
                    req[17] = i_cmp.ill;
                    req[7]  = trace_ok;
                    req[6]  = i_cmp.vassist;
                    req[5]  = i_cmp.iseg;
                    req[4]  = i_cmp.isto;
                end
            endcase
        end
        req[3] = i_async.maint && async_en;
        req[2] = i_async.ext   && async_en;
        req[1] = i_async.perf  && async_en;
        req[0] = i_async.dec   && async_en;
        // Highest-priority one-hot winner pick
        win = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i] && win == '0) begin
                win[i] = 1'b1;
            end
        end
        therm_win = (win == THERM_BIT) && i_async.therm && async_en;
        sel       = exu_exc_t'(win);
    end

    always_comb begin
        vec     = '0;
        save_ea = i_cmp.ea;
        unique case (sel)
            EX_SRST:  vec = V_SRST;
            EX_MCHK:  vec = V_MCHK;
            EX_PILL, EX_PPRIV, EX_FPEN: vec = V_PROG;
            EX_TRAP: begin
                vec = V_PROG;
                save_ea = i_cmp.next_ea;
            end
            EX_SC: begin
                vec = V_SC;
                save_ea = i_cmp.next_ea;
            end
            EX_TRACE: begin
                vec = V_TRCE;
                save_ea = i_cmp.next_ea;
            end
            EX_FPUN:  vec = V_FPUN;
            EX_VUN:   vec = V_VUN;
            EX_DSEG:  vec = V_DSEG;
            EX_DSTO:  vec = V_DSTO;
            EX_ALIGN: vec = V_ALGN;
            EX_VAST:  vec = V_VAST;
            EX_ISEG:  vec = V_ISEG;
            EX_ISTO:  vec = V_ISTO;
            EX_MAINT: vec = V_MNT;
            EX_EXT:   vec = V_EXT;
            EX_PERF:  vec = V_PERF;
            EX_DEC:   vec = V_DEC;
            EX_NONE:  vec = V_THRM;
            default:  vec = '0;
        endcase
    end

    logic        take;
    logic        mchk_stop;
    logic [63:0] info_bits;

    // Winners that an instruction caused; only they carry cause bits
    localparam logic [NSRC-1:0] INST_MASK = ~(EX_SRST | EX_MCHK | EX_MAINT | EX_EXT
                                              | EX_PERF | EX_DEC);

    always_comb begin
        st_nxt        = st_r;
        st_nxt.exc.take  = 1'b0;
        st_nxt.exc.flush = 1'b0;
        mchk_stop = (sel == EX_MCHK) && !st_r.msw[bix(MSW_MC_EN)];
        take      = !st_r.checkstop && !mchk_stop
                    && (win != '0 || therm_win);
        // Cause bits go to save-status positions 33:36 and 42:47
        // A released completion slot holds junk, so async winners save no cause
        info_bits = '0;
        if ((win & INST_MASK) != '0) begin
            info_bits[bix(33):bix(36)] = i_cmp.info[9:6];
            info_bits[bix(42):bix(47)] = i_cmp.info[5:0];
        end
        st_nxt.cmp_ok = i_store_q_empty && !i_store_q_cancel
                        && i_cmp.valid && i_cmp.done;
        st_nxt.exc.recoverable = st_r.msw[bix(MSW_RECOV)];
        if (mchk_stop) begin
            st_nxt.checkstop = 1'b1;
        end
        st_nxt.exc.checkstop = st_nxt.checkstop;
        if (take) begin
            st_nxt.exc.take   = 1'b1;
            st_nxt.exc.flush  = (sel == EX_FPEN);
            st_nxt.exc.target = vec + st_r.hior;
            st_nxt.sra = save_ea & SRA_MASK;
            st_nxt.sms = (st_r.msw & SMS_COPY_MASK)
                         | (info_bits & ~SMS_COPY_MASK);
            st_nxt.msw = '0;
            st_nxt.msw[bix(MSW_WIDE)] = 1'b1;
            st_nxt.msw[bix(MSW_MC_EN)] = (sel == EX_MCHK) ? 1'b0
                                          : st_r.msw[bix(MSW_MC_EN)];
            st_nxt.msw[bix(MSW_HYP)] = st_r.msw[bix(MSW_HYP)]
                                       || sel == EX_SC || sel == EX_SRST
                                       || sel == EX_MCHK;
        end else if (i_cmp.valid && i_cmp.done && i_cmp.iclass == IC_RFI) begin
            st_nxt.msw = st_r.sms;
            st_nxt.msw[bix(MSW_POW)] = 1'b0;
        end else if (i_cmp.valid && i_cmp.done && i_cmp.iclass == IC_MTSW) begin
            st_nxt.msw = i_wdata;
            st_nxt.msw[bix(MSW_HYP)] = st_r.msw[bix(MSW_HYP)];
            st_nxt.msw[bix(MSW_MC_EN)] = st_r.msw[bix(MSW_MC_EN)];
        end else if (i_wr && (i_addr >> 3) == '0) begin
            unique case (i_addr[2:0])
                A_SRA[2:0]:  st_nxt.sra  = i_wdata & SRA_MASK;
                A_SMS[2:0]:  st_nxt.sms  = i_wdata;
                A_HIOR[2:0]: st_nxt.hior = i_wdata;
                default: ;
            endcase
        end
        st_nxt.rdata = '0;
        if (i_rd && (i_addr >> 3) == '0) begin
            unique case (i_addr[2:0])
                A_SRA[2:0]:  st_nxt.rdata = st_r.sra;
                A_SMS[2:0]:  st_nxt.rdata = st_r.sms;
                A_MSW[2:0]:  st_nxt.rdata = st_r.msw;
                A_HIOR[2:0]: st_nxt.rdata = st_r.hior;
                A_STAT[2:0]: st_nxt.rdata = {62'h0, st_r.checkstop, st_r.cmp_ok};
                default:     st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r     <= '0;
            st_r.msw <= MSW_RESET;
        end else if (!rst_s2_r) begin
            st_r     <= '0;
            st_r.msw <= MSW_RESET;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata  = st_r.rdata;
    assign o_exc    = st_r.exc;
    assign o_msw    = st_r.msw;
    assign o_cmp_ok = st_r.cmp_ok;
endmodule

// File: exu_pkg.sv
// Package for the exception priority and state save unit
package exu_pkg;
    localparam int XLEN = 64;
    // Bit positions, numbered 0 = most significant as in the state word
    localparam int MSW_WIDE      = 0;
    localparam int MSW_HYP       = 3;
    localparam int MSW_VEC       = 38;
    localparam int MSW_POW       = 45;
    localparam int MSW_EXT_EN    = 48;
    localparam int MSW_USER      = 49;
    localparam int MSW_FP        = 50;
    localparam int MSW_MC_EN     = 51;
    localparam int MSW_FE0       = 52;
    localparam int MSW_STEP      = 53;
    localparam int MSW_BRTRACE   = 54;
    localparam int MSW_FE1       = 55;
    localparam int MSW_ITRANS    = 58;
    localparam int MSW_DTRANS    = 59;
    localparam int MSW_RECOV     = 62;
    // Helper: convert big-endian bit number to vector index
    function automatic int bix(input int b);
        return XLEN - 1 - b;
    endfunction
    // Save-status mask: bits 0:32, 37:41, 48:63 come from the state word
    localparam logic [63:0] SMS_COPY_MASK = 64'hFFFF_FFFF_87C0_FFFF;
    localparam logic [63:0] SRA_MASK      = 64'hFFFF_FFFF_FFFF_FFFC;
    localparam logic [63:0] MSW_RESET     = 64'h8000_0000_0000_1000;
    localparam logic [9:0]  INFO_ZERO     = 10'h000;
    // Register map on the plain port (word indices)
    localparam logic [3:0] A_SRA  = 4'h0;
    localparam logic [3:0] A_SMS  = 4'h1;
    localparam logic [3:0] A_MSW  = 4'h2;
    localparam logic [3:0] A_HIOR = 4'h3;
    localparam logic [3:0] A_STAT = 4'h4;
    // Winner codes, one-hot, highest priority first
    localparam int NSRC = 20;
    typedef enum logic [NSRC-1:0] {
        EX_NONE  = 20'h0_0000,
        EX_SRST  = 20'h8_0000, EX_MCHK  = 20'h4_0000, EX_PILL  = 20'h2_0000,
        EX_PPRIV = 20'h1_0000, EX_FPUN  = 20'h0_8000, EX_FPEN  = 20'h0_4000,
        EX_VUN   = 20'h0_2000, EX_TRAP  = 20'h0_1000, EX_SC    = 20'h0_0800,
        EX_DSEG  = 20'h0_0400, EX_DSTO  = 20'h0_0200, EX_ALIGN = 20'h0_0100,
        EX_TRACE = 20'h0_0080, EX_VAST  = 20'h0_0040, EX_ISEG  = 20'h0_0020,
        EX_ISTO  = 20'h0_0010, EX_MAINT = 20'h0_0008, EX_EXT   = 20'h0_0004,
        EX_PERF  = 20'h0_0002, EX_DEC   = 20'h0_0001
    } exu_exc_t;
    localparam logic [NSRC-1:0] THERM_BIT = 20'h0_0000;
    // Vector offsets
    localparam logic [63:0] V_SRST = 64'h0000_0000_0000_0100;
    localparam logic [63:0] V_MCHK = 64'h0000_0000_0000_0200;
    localparam logic [63:0] V_DSTO = 64'h0000_0000_0000_0300;
    localparam logic [63:0] V_DSEG = 64'h0000_0000_0000_0380;
    localparam logic [63:0] V_ISTO = 64'h0000_0000_0000_0400;
    localparam logic [63:0] V_ISEG = 64'h0000_0000_0000_0480;
    localparam logic [63:0] V_EXT  = 64'h0000_0000_0000_0500;
    localparam logic [63:0] V_ALGN = 64'h0000_0000_0000_0600;
    localparam logic [63:0] V_PROG = 64'h0000_0000_0000_0700;
    localparam logic [63:0] V_FPUN = 64'h0000_0000_0000_0800;
    localparam logic [63:0] V_DEC  = 64'h0000_0000_0000_0900;
    localparam logic [63:0] V_SC   = 64'h0000_0000_0000_0C00;
    localparam logic [63:0] V_TRCE = 64'h0000_0000_0000_0D00;
    localparam logic [63:0] V_PERF = 64'h0000_0000_0000_0F00;
    localparam logic [63:0] V_VUN  = 64'h0000_0000_0000_0F20;
    localparam logic [63:0] V_MNT  = 64'h0000_0000_0000_1600;
    localparam logic [63:0] V_VAST = 64'h0000_0000_0000_1700;
    localparam logic [63:0] V_THRM = 64'h0000_0000_0000_1800;
    // Instruction class of the next completing instruction
    typedef enum logic [2:0] {
        IC_FXLS = 3'h0, IC_FPLS = 3'h1, IC_FPOP = 3'h2, IC_VEC = 3'h3,
        IC_RFI  = 3'h4, IC_MTSW = 3'h5, IC_OTHER = 3'h6, IC_BRANCH = 3'h7
    } exu_iclass_t;
    // Completion pipeline request
    typedef struct packed {
        logic              valid;      // next instruction is at completion
        exu_iclass_t       iclass;
        logic [63:0]       ea;         // its effective address
        logic [63:0]       next_ea;    // address of the following instruction
        logic              ill;        // illegal instruction
        logic              priv_op;    // privileged opcode
        logic              fp_exc;     // enabled IEEE exception detected
        logic              trap;
        logic              syscall;
        logic              dseg;
        logic              dsto;
        logic              align;
        logic              vassist;
        logic              iseg;
        logic              isto;
        logic              isync;
        logic              done;       // registers updated, left the buffer
        logic [9:0]        info;       // cause bits for 33:36, 42:47
    } exu_cmp_t;
    // Asynchronous sources
    typedef struct packed {
        logic srst;
        logic mchk;
        logic maint;
        logic ext;
        logic perf;
        logic dec;
        logic therm;
    } exu_async_t;
    // Exception entry / return outcome
    typedef struct packed {
        logic        take;
        logic        flush;       // refetch instructions individually
        logic [63:0] target;
        logic        checkstop;
        logic        recoverable;
    } exu_out_t;
endpackage

// File: exu_asserts.sv
// Port checker for the exception unit
`timescale 1ns/10ps
module exu_asserts
    import exu_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic                i_core_clk,
    input wire logic                i_arst_n,
    input wire logic                i_clk_en,
    input wire exu_pkg::exu_cmp_t   i_cmp,
    input wire exu_pkg::exu_async_t i_async,
    input wire logic                i_store_q_empty,
    input wire logic                i_store_q_cancel,
    input wire logic [ADDR_W-1:0]   i_addr,
    input wire logic [63:0]         i_wdata,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire logic [63:0]         o_rdata,
    input wire exu_pkg::exu_out_t   o_exc,
    input wire logic [63:0]         o_msw,
    input wire logic                o_cmp_ok
);
    logic [1:0] up_r;
    logic       rdy;
    // Skip the first three edges; the design spends two leaving reset
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            up_r <= 2'd0;
        end else if (up_r != 2'd3) begin
            up_r <= up_r + 2'd1;
        end
    end
    assign rdy = (up_r == 2'd3) && i_clk_en;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    a_ext_masked: assert property (rdy && !o_msw[bix(MSW_EXT_EN)] && !i_async.srst
        && !i_async.mchk && !i_cmp.valid |=> !o_exc.take) else $error("masked source taken");
    a_mchk_stop: assert property (rdy && i_async.mchk && !i_async.srst
        && !o_msw[bix(MSW_MC_EN)] |=> o_exc.checkstop && !o_exc.take) else $error("no checkstop");
    a_stop_sticky: assert property (o_exc.checkstop |=> o_exc.checkstop && !o_exc.take)
        else $error("checkstop left or taken");
    a_srst_first: assert property (rdy && i_async.srst && !o_exc.checkstop
        |=> o_exc.take && o_exc.target[15:0] == V_SRST[15:0]) else $error("reset not first");
    a_entry_clear: assert property (o_exc.take |-> o_msw[63]
        && (o_msw & 64'h6FFF_FFFF_FFFF_EFFF) == '0) else $error("state word not cleared");
    a_sra_low: assert property (rdy && i_rd && i_addr == A_SRA |=> o_rdata[1:0] == 2'b00)
        else $error("return address low bits set");
    a_cmp_ok: assert property (rdy |=> o_cmp_ok ==
        $past(i_store_q_empty && !i_store_q_cancel && i_cmp.valid && i_cmp.done))
        else $error("bad recover flag");
    a_flush_take: assert property (o_exc.flush |-> o_exc.take)
        else $error("flush without take");
    a_fp_off: assert property (rdy && i_cmp.valid && !o_msw[bix(MSW_FE0)]
        && !o_msw[bix(MSW_FE1)] |=> !o_exc.flush) else $error("flush with fp off");
    c_take: cover property (o_exc.take);
    c_flush: cover property (o_exc.flush);
    c_stop: cover property ($rose(o_exc.checkstop));
endmodule
bind exu_top exu_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_cmp(i_cmp),
    .i_async(i_async), .i_store_q_empty(i_store_q_empty), .i_store_q_cancel(i_store_q_cancel),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_exc(o_exc), .o_msw(o_msw), .o_cmp_ok(o_cmp_ok)
);

// File: exu_far_model.sv
// Model of the completion pipeline and the interrupt sources
`timescale 1ns/10ps
module exu_far_model
    import exu_pkg::*;
(
    input  wire logic            i_core_clk,
    output exu_pkg::exu_cmp_t    o_cmp,
    output exu_pkg::exu_async_t  o_async
);
    int       c_cnt = 0;
    int       a_cnt = 0;
    exu_cmp_t rel;
    initial begin
        o_cmp = '0;
        o_async = '0;
    end
    task automatic issue(input exu_cmp_t c);
        o_cmp <= c;
        c_cnt <= 1;
    endtask
    task automatic raise(input exu_async_t a, input int hold);
        o_async <= a;
        a_cnt <= hold;
    endtask
    // A completed slot is withdrawn with its payload scrambled
    always @(posedge i_core_clk) begin
        if (c_cnt == 1) begin
            rel = ~o_cmp;
            rel.valid = 1'b0;
            o_cmp <= rel;
            c_cnt <= 0;
        end
        if (a_cnt == 1) begin
            o_async <= '0;
        end
        if (a_cnt > 0) begin
            a_cnt <= a_cnt - 1;
        end
    end
endmodule

// File: tb_exception_priority_and_state_save.sv
// Self-checking testbench for the exception unit
`timescale 1ns/10ps
module tb_exception_priority_and_state_save;
    import exu_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sq_empty = 1'b1;
    logic        sq_cancel = 1'b0;
    logic [3:0]  addr = '0;
    logic [63:0] wdata = '0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [63:0] rdata;
    exu_out_t    exc;
    exu_out_t    eo;
    logic [63:0] msw;
    logic        cmp_ok;
    exu_cmp_t    cmp;
    exu_async_t  asy;
    exu_async_t  a;
    logic [63:0] hior;
    logic [63:0] rv;
    logic [63:0] ee;
    logic [63:0] vv [5] = '{V_MNT, V_EXT, V_PERF, V_DEC, V_THRM};
    int          n_mismatch = 0;
    int          total_checks = 0;
    always #25 clk = ~clk;
    exu_far_model u_far (.i_core_clk(clk), .o_cmp(cmp), .o_async(asy));
    exu_top #(.ADDR_W(4)) uut (
        .i_core_clk(clk), .i_arst_n(arst_n), .i_clk_en(1'b1), .i_cmp(cmp), .i_async(asy),
        .i_store_q_empty(sq_empty), .i_store_q_cancel(sq_cancel), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_exc(exc), .o_msw(msw),
        .o_cmp_ok(cmp_ok)
    );
    always @(posedge clk) begin
        sq_empty <= ($urandom % 4) != 0;
        sq_cancel <= ($urandom % 8) == 0;
    end
    function automatic logic [63:0] bt(input int b);
        return 64'h1 << (63 - b);
    endfunction
    task automatic print_verdict;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] ad, input logic [63:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] ad, output logic [63:0] d);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic see_take(input logic want, output exu_out_t e);
        e = '0;
        for (int i = 0; i < 6 && !e.take; i++) begin
            @(posedge clk);
            #1;
            if (exc.take === 1'b1) e = exc;
        end
        chk({63'd0, e.take}, {63'd0, want});
        if (want && e.take !== 1'b1) print_verdict();
    endtask
    task automatic set_msw(input logic [63:0] m);
        exu_cmp_t c;
        c = '0;
        c.valid = 1'b1;
        c.iclass = IC_RFI;
        c.done = 1'b1;
        wr_reg(A_SMS, m);
        @(posedge clk);
        u_far.issue(c);
        repeat (2) @(posedge clk);
        #1;
        chk(msw, m & ~bt(MSW_POW));
    endtask
    task automatic acase(input logic [63:0] m, input exu_async_t s, input int h,
                         input logic [63:0] vec);
        exu_out_t e;
        set_msw(m);
        @(posedge clk);
        u_far.raise(s, h);
        see_take(1'b1, e);
        chk(e.target, vec + hior);
        chk({63'd0, e.recoverable}, {63'd0, m[63-MSW_RECOV]});
        rd_reg(A_SMS, rv);
        chk(rv, m & SMS_COPY_MASK);
    endtask
    task automatic icase(input exu_iclass_t ic, input logic [10:0] f, input logic [63:0] m,
                         input logic [63:0] vec, input logic nxt, input logic fl);
        exu_cmp_t c;
        exu_out_t e;
        c = '0;
        c.valid = 1'b1;
        c.iclass = ic;
        c.done = 1'b1;
        c.ea = {$urandom, $urandom} & SRA_MASK;
        c.next_ea = c.ea + 64'd4;
        {c.ill, c.priv_op, c.fp_exc, c.trap, c.syscall, c.dseg, c.dsto, c.align,
         c.vassist, c.iseg, c.isto} = f;
        set_msw(m);
        @(posedge clk);
        u_far.issue(c);
        see_take(vec != '0, e);
        if (vec != '0) begin
            chk(e.target, vec + hior);
            chk({63'd0, e.flush}, {63'd0, fl});
            rd_reg(A_SRA, rv);
            chk(rv, nxt ? c.next_ea : c.ea);
            rd_reg(A_SMS, rv);
            chk(rv, m & SMS_COPY_MASK);
        end
    endtask
    initial begin
        void'($urandom(32'h437b));
        hior = {$urandom, $urandom} & 64'hFFFF_FFFF_FFFF_0000;
        ee = MSW_RESET | bt(MSW_EXT_EN);
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(A_MSW, rv);
        chk(rv, MSW_RESET);
        wr_reg(A_MSW, '1);
        rd_reg(A_MSW, rv);
        chk(rv, MSW_RESET);
        rd_reg(4'hF, rv);
        chk(rv, '0);
        wr_reg(A_HIOR, hior);
        rd_reg(A_HIOR, rv);
        chk(rv, hior);
        rd_reg(4'hB, rv);
        chk(rv, '0);
        wr_reg(A_SRA, '1);
        rd_reg(A_SRA, rv);
        chk(rv, SRA_MASK);
        set_msw(ee | bt(MSW_POW));
        set_msw(MSW_RESET);
        a = '0;
        a.ext = 1'b1;
        u_far.raise(a, 2);
        see_take(1'b0, eo);
        for (int k = 0; k < 5; k++) begin
            a = '0;
            a.maint = k <= 0;
            a.ext = k <= 1;
            a.perf = k <= 2;
            a.dec = k <= 3;
            a.therm = 1'b1;
            acase(ee | (($urandom % 2) ? bt(MSW_RECOV) : '0), a, 1 + $urandom % 3, vv[k]);
        end
        a = '0;
        a.srst = 1'b1;
        a.mchk = 1'b1;
        a.ext = 1'b1;
        acase(ee, a, 1, V_SRST);
        a = '0;
        a.mchk = 1'b1;
        acase(ee | bt(MSW_RECOV), a, 1, V_MCHK);
        chk(msw, bt(MSW_WIDE) | bt(MSW_HYP));
        icase(IC_FXLS, 11'h428, MSW_RESET, V_PROG, 1'b0, 1'b0);
        icase(IC_FXLS, 11'h018, MSW_RESET, V_DSTO, 1'b0, 1'b0);
        icase(IC_FXLS, 11'h220, MSW_RESET, V_DSEG, 1'b0, 1'b0);
        icase(IC_FXLS, 11'h220, MSW_RESET | bt(MSW_USER), V_PROG, 1'b0, 1'b0);
        icase(IC_FPLS, 11'h020, MSW_RESET, V_FPUN, 1'b0, 1'b0);
        icase(IC_FPLS, 11'h030, MSW_RESET | bt(MSW_FP), V_DSEG, 1'b0, 1'b0);
        icase(IC_FPOP, 11'h100, MSW_RESET | bt(MSW_FP) | bt(MSW_FE0), V_PROG, 1'b0, 1'b1);
        icase(IC_FPOP, 11'h100, MSW_RESET, V_FPUN, 1'b0, 1'b0);
        icase(IC_FPOP, 11'h100, MSW_RESET | bt(MSW_FP), '0, 1'b0, 1'b0);
        icase(IC_VEC, 11'h000, MSW_RESET, V_VUN, 1'b0, 1'b0);
        icase(IC_VEC, 11'h000, MSW_RESET | bt(MSW_VEC), '0, 1'b0, 1'b0);
        icase(IC_RFI, 11'h100, MSW_RESET | bt(MSW_FP) | bt(MSW_FE1), V_PROG, 1'b0, 1'b1);
        icase(IC_RFI, 11'h000, MSW_RESET | bt(MSW_STEP), '0, 1'b0, 1'b0);
        icase(IC_MTSW, 11'h000, MSW_RESET | bt(MSW_STEP), V_TRCE, 1'b1, 1'b0);
        icase(IC_OTHER, 11'h042, MSW_RESET, V_SC, 1'b1, 1'b0);
        icase(IC_OTHER, 11'h080, MSW_RESET, V_PROG, 1'b1, 1'b0);
        icase(IC_OTHER, 11'h007, MSW_RESET, V_VAST, 1'b0, 1'b0);
        icase(IC_OTHER, 11'h003, MSW_RESET, V_ISEG, 1'b0, 1'b0);
        icase(IC_OTHER, 11'h001, MSW_RESET, V_ISTO, 1'b0, 1'b0);
        set_msw(bt(MSW_WIDE));
        a = '0;
        a.mchk = 1'b1;
        u_far.raise(a, 1);
        see_take(1'b0, eo);
        chk({63'd0, exc.checkstop}, 64'd1);
        rd_reg(A_STAT, rv);
        chk({63'd0, rv[1]}, 64'd1);
        print_verdict();
    end
endmodule
